// File: core/cmpc_top.sv
// Purpose: Two-channel comparator control and status with AXI4-Lite registers
// Assumes: Timer clock levels arrive synchronous to clk
// Notes:   Analog core, references, timer and interrupt controller are outside
//
// How it works
// - Speed select resets to 1 (fast); clearing it picks low power.
// - Hysteresis output follows the hysteresis enable bit.
// - In sync mode the output is latched on timer clock falling edges.
// - With timer prescaler on, the prescaled clock drives the latch.
// - Rising and falling detectors per channel set the channel flag.
// - Only software clears the flag; a coincident edge keeps it set.
// - Polarity or enable toggles still create edges while disabled.
// - Enable bit 7 powers the comparator; clear means off.
// - Read-only status bit 6 shows the result after polarity.
// - Pin drive enable routes the result regardless of the enable bit.
// - Polarity bit inverts status, pin and edge detection alike.
// - Sync bit 0 makes timer and pin outputs timer-synchronous.
// - Bits 7 and 6 enable flag setting on rising and falling edges.
// - Positive select 00 pin, 01 DAC, 10 fixed ref, 11 ground.
// - Negative select 000-011 pins, 100 fixed ref, 101-111 reserved.
// - Pins set analog read as zero in the port value.
// - Status registered every cycle; pin path latched only in sync mode.
// - Mirror register holds channel 1 in bit 0, channel 2 in bit 1.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module cmpc_top (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset,
  // AXI4-Lite write address
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [cmpc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // AXI4-Lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [cmpc_pkg::ADDR_W-1:0]  s_axi_araddr,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // Analog core
  input  wire logic [cmpc_pkg::NUM_CH-1:0]  raw_cmp,
  output logic [cmpc_pkg::NUM_CH-1:0]       cmp_enable_bit,
  output logic [cmpc_pkg::NUM_CH-1:0]       cmp_speed_power_select,
  output logic [cmpc_pkg::NUM_CH-1:0]       cmp_hysteresis_enable,
  output logic [cmpc_pkg::NUM_CH-1:0][1:0]  positive_channel_select,
  output logic [cmpc_pkg::NUM_CH-1:0][2:0]  negative_channel_select,
  // Timer clocks
  input  wire logic                         t1_src_clk,
  input  wire logic                         t1_prescaled_clk,
  input  wire logic                         t1_prescale_on,
  // Results toward timer gate and pins
  output logic [cmpc_pkg::NUM_CH-1:0]       timer_gate_out,
  output logic [cmpc_pkg::NUM_CH-1:0]       cmp_pin_out,
  output logic [cmpc_pkg::NUM_CH-1:0]       cmp_pin_drive_enable,
  // Interrupt controller
  output logic [cmpc_pkg::NUM_CH-1:0]       cmp_irq_flag,
  // Port pins
  input  wire logic [7:0]                   port_pin_level
);
  import cmpc_pkg::*;

  // ==========================================================
  // Bus state
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              wr_en;
  logic              wr_hit;
  logic [7:0]        rd_val;
  logic              rd_hit;

  // Shared registers and timer edge
  logic [7:0]        ansel_q;
  logic              t1_prev_q;
  logic              t1_sel;
  logic              t1_fall;

  // Per-channel registers
  logic [NUM_CH-1:0][7:0] con0_q;
  logic [NUM_CH-1:0][7:0] con1_q;
  logic [NUM_CH-1:0]      status;
  logic [NUM_CH-1:0]      gate_q;
  logic [NUM_CH-1:0]      pin_q;
  logic [NUM_CH-1:0]      flag_w;

  // Write fires once both halves are held and no answer is pending
  assign wr_en = aw_held_q & w_held_q & ~bvalid_q;

  // ==========================================================
  // Write address and data capture
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held_q <= 1'b0;
      awready_q <= 1'b1;
      waddr_q   <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_held_q <= 1'b1;
      awready_q <= 1'b0;
      waddr_q   <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_held_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      w_held_q <= 1'b0;
      wready_q <= 1'b1;
      wbyte_q  <= '0;
      wlane_q  <= 1'b0;
    end else if (s_axi_wvalid && wready_q) begin
      w_held_q <= 1'b1;
      wready_q <= 1'b0;
      wbyte_q  <= s_axi_wdata[7:0];
      wlane_q  <= s_axi_wstrb[0];
    end else if (wr_en) begin
      w_held_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  // ==========================================================
  // Write decode
  always_comb begin
    wr_hit = 1'b0;
    if (waddr_q == OFF_CON0 || waddr_q == OFF_CON1) begin
      wr_hit = 1'b1;
    end else if (waddr_q == 8'(OFF_CON0 + CH_STRIDE)) begin
      wr_hit = 1'b1;
    end else if (waddr_q == 8'(OFF_CON1 + CH_STRIDE)) begin
      wr_hit = 1'b1;
    end else if (waddr_q == OFF_MIRROR || waddr_q == OFF_PORT) begin
      wr_hit = 1'b1;
    end else if (waddr_q == OFF_FLAGS || waddr_q == OFF_ANSEL) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Analog select, defaults to all analog
  always_ff @(posedge clk) begin
    if (reset) begin
      ansel_q <= ANSEL_RST;
    end else if (wr_en && wlane_q && waddr_q == OFF_ANSEL) begin
      ansel_q <= wbyte_q;
    end
  end

  // ==========================================================
  // Timer clock edge
  // prescaled clock when prescaler used
  assign t1_sel = t1_prescale_on ? t1_prescaled_clk : t1_src_clk;
  // falling edge only, timer keeps rising edge
  assign t1_fall = t1_prev_q & ~t1_sel;

  always_ff @(posedge clk) begin
    if (reset) begin
      t1_prev_q <= 1'b0;
    end else begin
      t1_prev_q <= t1_sel;
    end
  end

  // ==========================================================
  // Channels
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [7:0] A_CON0 = 8'(OFF_CON0 + i * CH_STRIDE);
    localparam logic [7:0] A_CON1 = 8'(OFF_CON1 + i * CH_STRIDE);
    cmpc_chan_if cif ();

    always_ff @(posedge clk) begin
      if (reset) begin
        con0_q[i] <= CON0_RST;
      end else if (wr_en && wlane_q && waddr_q == A_CON0) begin
        con0_q[i] <= wbyte_q & CON0_WMASK;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        con1_q[i] <= CON1_RST;
      end else if (wr_en && wlane_q && waddr_q == A_CON1) begin
        con1_q[i] <= wbyte_q & CON1_WMASK;
      end
    end

    assign cif.on       = con0_q[i][B_ON];
    assign cif.pol      = con0_q[i][B_POL];
    assign cif.sync     = con0_q[i][B_SYNC];
    assign cif.intp     = con1_q[i][B_INTP];
    assign cif.intn     = con1_q[i][B_INTN];
    assign cif.t1_fall  = t1_fall;
    assign cif.flag_clr = wr_en && wlane_q && waddr_q == OFF_FLAGS && wbyte_q[i];

    cmpc_channel u_chan (
      .clk     (clk),
      .reset   (reset),
      .raw_cmp (raw_cmp[i]),
      .cif     (cif.chan)
    );

    assign status[i] = cif.status;
    assign flag_w[i] = cif.flag;

    // pin follows result regardless of enable
    always_ff @(posedge clk) begin
      if (reset) begin
        gate_q[i] <= 1'b0;
        pin_q[i]  <= 1'b0;
      end else begin
        gate_q[i] <= cif.timer_out;
        pin_q[i]  <= cif.pin_out;
      end
    end

    // enable drives the analog core power
    assign cmp_enable_bit[i]          = con0_q[i][B_ON];
    assign cmp_speed_power_select[i]  = con0_q[i][B_SP];
    assign cmp_hysteresis_enable[i]   = con0_q[i][B_HYS];
    assign cmp_pin_drive_enable[i]    = con0_q[i][B_OE];
    assign positive_channel_select[i] = con1_q[i][PCH_LSB +: 2];
    assign negative_channel_select[i] = con1_q[i][NCH_LSB +: 3];
  end

  assign timer_gate_out = gate_q;
  assign cmp_pin_out    = pin_q;
  assign cmp_irq_flag   = flag_w;

  // ==========================================================
  // Read decode
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr == OFF_CON0) begin
      rd_val        = con0_q[0];
      rd_val[B_OUT] = status[0];
    end else if (s_axi_araddr == OFF_CON1) begin
      rd_val = con1_q[0];
    end else if (s_axi_araddr == 8'(OFF_CON0 + CH_STRIDE)) begin
      rd_val        = con0_q[1];
      rd_val[B_OUT] = status[1];
    end else if (s_axi_araddr == 8'(OFF_CON1 + CH_STRIDE)) begin
      rd_val = con1_q[1];
    end else if (s_axi_araddr == OFF_MIRROR) begin
      rd_val = {6'h00, status};
    end else if (s_axi_araddr == OFF_FLAGS) begin
      rd_val = {6'h00, flag_w};
    end else if (s_axi_araddr == OFF_ANSEL) begin
      rd_val = ansel_q;
    end else if (s_axi_araddr == OFF_PORT) begin
      rd_val = port_pin_level & ~ansel_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_val};
      rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule

// File: core/cmpc_pkg.sv
// Purpose: Shared constants for the comparator control block
// Assumes: 8-bit registers, one per aligned 32-bit word
// Notes:   Offsets are byte addresses on the register bus
package cmpc_pkg;
  // ==========================================================
  // Geometry
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 8;
  localparam int REG_W  = 8;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_CON0   = 8'h00;
  localparam logic [7:0] OFF_CON1   = 8'h04;
  localparam logic [7:0] CH_STRIDE  = 8'h08;
  localparam logic [7:0] OFF_MIRROR = 8'h10;
  localparam logic [7:0] OFF_FLAGS  = 8'h14;
  localparam logic [7:0] OFF_ANSEL  = 8'h18;
  localparam logic [7:0] OFF_PORT   = 8'h1C;

  // ==========================================================
  // Main control fields
  localparam int B_ON   = 7;
  localparam int B_OUT  = 6;
  localparam int B_OE   = 5;
  localparam int B_POL  = 4;
  localparam int B_SP   = 2;
  localparam int B_HYS  = 1;
  localparam int B_SYNC = 0;

  // ==========================================================
  // Input and edge select fields
  localparam int B_INTP  = 7;
  localparam int B_INTN  = 6;
  localparam int PCH_LSB = 4;
  localparam int NCH_LSB = 0;

  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0] CON0_WMASK = 8'hB7;
  localparam logic [7:0] CON1_WMASK = 8'hF7;
  localparam logic [7:0] CON0_RST   = 8'h04;
  localparam logic [7:0] CON1_RST   = 8'h00;
  localparam logic [7:0] ANSEL_RST  = 8'hFF;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: core/cmpc_chan_if.sv
// Purpose: Carrier between register file and one channel core
// Assumes: Single clock domain
// Notes:   ctrl side drives settings, chan side returns results
`timescale 1ns/1ps
interface cmpc_chan_if;
  logic on;
  logic pol;
  logic sync;
  logic intp;
  logic intn;
  logic flag_clr;
  logic t1_fall;
  logic status;
  logic timer_out;
  logic pin_out;
  logic flag;

  modport ctrl (output on, pol, sync, intp, intn, flag_clr, t1_fall,
                input  status, timer_out, pin_out, flag);
  modport chan (input  on, pol, sync, intp, intn, flag_clr, t1_fall,
                output status, timer_out, pin_out, flag);
endinterface

// File: core/cmpc_channel.sv
// Purpose: One comparator channel: result capture, sync latch, edge flag
// Assumes: Raw decision is asynchronous; t1_fall is a one-cycle pulse
// Notes:   All results are registered
`timescale 1ns/1ps
module cmpc_channel (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Analog decision
  input  wire logic raw_cmp,
  // Register side
  cmpc_chan_if.chan cif
);
  import cmpc_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic status_q;
  logic latch_q;
  logic flag_q;
  logic result_d;
  logic rise;
  logic fall;

  // ==========================================================
  // two-stage synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= raw_cmp;
      sync2_q <= sync1_q;
    end
  end

  // off forces the polarity level, so on and polarity toggles still make edges
  assign result_d = (cif.on & sync2_q) ^ cif.pol;

  // ==========================================================
  // status captured every cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= 1'b0;
    end else begin
      status_q <= result_d;
    end
  end

  // latch on falling timer clock edge in sync mode, else every cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_q <= 1'b0;
    end else if (!cif.sync || cif.t1_fall) begin
      latch_q <= result_d;
    end
  end

  // ==========================================================
  // separate edge detectors
  assign rise = result_d & ~status_q & cif.intp;
  assign fall = ~result_d & status_q & cif.intn;

  always_ff @(posedge clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= (flag_q & ~cif.flag_clr) | rise | fall;
    end
  end

  assign cif.status    = status_q;
  assign cif.timer_out = latch_q;
  assign cif.pin_out   = latch_q;
  assign cif.flag      = flag_q;
endmodule

// File: tb/cmpc_props.sv
// Purpose: Port-level timing checks for cmpc_top
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every cmpc_top instance
`timescale 1ns/1ps
module cmpc_props
  import cmpc_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  // Results
  input wire logic [NUM_CH-1:0] cmp_speed_power_select,
  input wire logic [NUM_CH-1:0] timer_gate_out,
  input wire logic [NUM_CH-1:0] cmp_pin_out,
  input wire logic [NUM_CH-1:0] cmp_irq_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Bus handshakes
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");
  property p_rd_resp;
    s_rd_taken |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_rresp_legal;
    s_axi_rvalid |-> s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR;
  endproperty
  a_rresp_legal: assert property (p_rresp_legal) else $error("bad read code");

  // ==========================================================
  // Register and result behaviour
  property p_upper_zero;
    s_axi_rvalid && s_axi_rresp == RESP_OKAY |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_speed_rst;
    $fell(reset) |-> cmp_speed_power_select == 2'h3;
  endproperty
  a_speed_rst: assert property (p_speed_rst) else $error("speed not fast");
  // Flag only falls when a write completes
  property p_flag_clear;
    (($past(cmp_irq_flag) & ~cmp_irq_flag) != 2'h0) |-> $rose(s_axi_bvalid);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag fell alone");
  property p_out_pair;
    timer_gate_out == cmp_pin_out;
  endproperty
  a_out_pair: assert property (p_out_pair) else $error("timer and pin differ");
endmodule

bind cmpc_top cmpc_props cmpc_props_inst (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .cmp_speed_power_select, .timer_gate_out, .cmp_pin_out, .cmp_irq_flag);

// File: tb/cmpc_timer_model.sv
// Purpose: Timer clock source and interrupt gate beside the comparator
// Assumes: Clocks are made synchronous to clk
// Notes:   Clocks stand still while their run input is low
`timescale 1ns/1ps
module cmpc_timer_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control from bench
  input  wire logic       run_src,
  input  wire logic       run_pre,
  input  wire logic [1:0] irq_en,
  input  wire logic       global_en,
  input  wire logic [1:0] cmp_irq_flag,
  // Toward the comparator block
  output logic            t1_src_clk,
  output logic            t1_prescaled_clk,
  output logic            cpu_irq
);
  logic [1:0]  ph_q;
  logic        pre_q;
  logic [15:0] count_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ph_q <= 2'h0;
    end else if (run_src) begin
      ph_q <= ph_q + 2'h1;
    end
  end
  // Prescaled clock halves the source clock
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_q <= 1'b0;
    end else if (run_src && run_pre && ph_q == 2'h3) begin
      pre_q <= ~pre_q;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= 16'h0000;
    end else if (run_src && ph_q == 2'h1) begin
      count_q <= count_q + 16'h0001;
    end
  end
  assign t1_src_clk       = ph_q[1];
  assign t1_prescaled_clk = pre_q;
  assign cpu_irq = global_en && |(cmp_irq_flag & irq_en);
endmodule

// File: tb/cmpc_top_bench.sv
// Purpose: Register-level tests of cmpc_top
// Assumes: AXI4-Lite master tasks, partner timer model
// Notes:   Fixed settle waits cover the four-edge result path to the pins and timer gate
`timescale 1ns/1ps
module cmpc_top_bench;
  import cmpc_pkg::*;
  // ==========================================================
  // Signals
  logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NUM_CH-1:0] raw_cmp, cmp_enable_bit, cmp_speed_power_select, cmp_hysteresis_enable;
  logic [NUM_CH-1:0] timer_gate_out, cmp_pin_out, cmp_pin_drive_enable, cmp_irq_flag;
  logic [NUM_CH-1:0][1:0] positive_channel_select;
  logic [NUM_CH-1:0][2:0] negative_channel_select;
  logic t1_src_clk, t1_prescaled_clk, t1_prescale_on, run_src, run_pre, cpu_irq, global_irq_enable;
  logic [7:0] port_pin_level;
  logic [1:0] r;
  logic [31:0] d;
  int bad_count, checked;
  localparam logic [31:0] RST_TAB [8] = '{32'h04, 32'h00, 32'h04, 32'h00,
                                          32'h00, 32'h00, 32'hFF, 32'h00};

  cmpc_top cmpc_top_inst (.clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .raw_cmp, .cmp_enable_bit,
    .cmp_speed_power_select, .cmp_hysteresis_enable, .positive_channel_select,
    .negative_channel_select, .t1_src_clk, .t1_prescaled_clk, .t1_prescale_on,
    .timer_gate_out, .cmp_pin_out, .cmp_pin_drive_enable, .cmp_irq_flag, .port_pin_level);
  cmpc_timer_model cmpc_timer_model_inst (.clk, .reset, .run_src, .run_pre,
    .irq_en(2'h3), .global_en(global_irq_enable), .cmp_irq_flag, .t1_src_clk, .t1_prescaled_clk,
    .cpu_irq);

  // ==========================================================
  // Tasks
  task automatic stop_test();
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    while (aw || w) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk(v, e);
  endtask
  task automatic raw(input logic [1:0] v);
    @(posedge clk);
    raw_cmp <= v;
    settle(8);
  endtask

  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200_000;
    bad_count++;
    stop_test();
  end
  initial begin
    {reset, run_src, run_pre, global_irq_enable} = 4'b1001;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hF;
    {raw_cmp, t1_prescale_on} = 3'h0;
    port_pin_level = 8'hA5;
    settle(20);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rchk(8'(i * 4), RST_TAB[i]);
    wr(8'h08, 32'hFF, r);
    chk(r, RESP_OKAY);
    rchk(8'h08, 32'hF7);
    chk({cmp_enable_bit, cmp_hysteresis_enable, cmp_pin_drive_enable}, 6'h2A);
    wr(8'h08, 32'h00, r);
    chk({cmp_enable_bit, cmp_hysteresis_enable, cmp_speed_power_select}, 6'h01);
    for (int i = 0; i < 8; i++) begin
      wr(8'h0C, 32'(i[1:0] * 16 + 8 + i[2:0]), r);
      rchk(8'h0C, 32'(i[1:0] * 16 + i[2:0]));
      chk({positive_channel_select[1], negative_channel_select[1]}, 5'(i[1:0] * 8 + i[2:0]));
    end
    wr(8'h08, 32'h80, r);
    raw(2'b10);
    rchk(8'h10, 32'h02);
    rchk(8'h08, 32'hC0);
    wr(8'h00, 32'h81, r);
    raw(2'b11);
    rchk(8'h10, 32'h03);
    chk(cmp_pin_out[0], 1'b0);
    run_src <= 1'b1;
    settle(16);
    chk({timer_gate_out[0], cmp_pin_out[0]}, 2'b11);
    t1_prescale_on <= 1'b1;
    raw(2'b10);
    settle(8);
    chk(cmp_pin_out[0], 1'b1);
    run_pre <= 1'b1;
    settle(24);
    chk(cmp_pin_out[0], 1'b0);
    {run_src, run_pre, t1_prescale_on} <= 3'b000;
    wr(8'h00, 32'h80, r);
    wr(8'h04, 32'h80, r);
    wr(8'h14, 32'h03, r);
    raw(2'b11);
    chk({cmp_irq_flag, cmp_pin_out[0], cpu_irq}, 4'b0111);
    global_irq_enable <= 1'b0;
    settle(1);
    chk(cpu_irq, 1'b0);
    global_irq_enable <= 1'b1;
    wr(8'h14, 32'h01, r);
    chk(cmp_irq_flag, 2'b00);
    raw(2'b10);
    chk(cmp_irq_flag, 2'b00);
    wr(8'h04, 32'h40, r);
    raw(2'b11);
    chk(cmp_irq_flag, 2'b00);
    raw(2'b10);
    rchk(8'h14, 32'h01);
    wr(8'h14, 32'h01, r);
    wr(8'h00, 32'h30, r);
    settle(4);
    rchk(8'h00, 32'h70);
    chk({cmp_pin_drive_enable[0], cmp_pin_out[0], cmp_enable_bit[0]}, 3'b110);
    wr(8'h00, 32'h20, r);
    settle(4);
    chk(cmp_irq_flag, 2'b01);
    wr(8'h20, 32'h01, r);
    chk(r, RESP_SLVERR);
    rd(8'h20, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h18, 32'h0F, r);
    rchk(8'h1C, 32'hA0);
    stop_test();
  end
endmodule
